/* File: core/clkc_defs.svh */
// Register offsets, field positions, reset values and timing figures of the clock selector.
`ifndef CLKC_DEFS_SVH
`define CLKC_DEFS_SVH

`define CLKC_CTRL_OFS 12'h000
`define CLKC_LFCTRL_OFS 12'h004
`define CLKC_TRIM_OFS 12'h008
`define CLKC_STATUS_OFS 12'h00c

`define CLKC_CTRL_SRC_RC 0
`define CLKC_CTRL_MANUAL 1
`define CLKC_CTRL_DIV_LSB 2
`define CLKC_CTRL_DIV_MSB 4

`define CLKC_LF_MODE_LSB 0
`define CLKC_LF_MODE_MSB 1
`define CLKC_LF_NOW 2
`define CLKC_LF_IN_PU 3
`define CLKC_LF_OUT_PU 4

`define CLKC_TRIM_HS_LSB 0
`define CLKC_TRIM_HS_MSB 5
`define CLKC_TRIM_PULL_LSB 8
`define CLKC_TRIM_PULL_MSB 11
`define CLKC_TRIM_CUR_LSB 16
`define CLKC_TRIM_CUR_MSB 17

`define CLKC_ST_SRC_RC 0
`define CLKC_ST_HS_RDY 1
`define CLKC_ST_LF_RDY 2
`define CLKC_ST_LF_SRC_LSB 4
`define CLKC_ST_LF_SRC_MSB 5
`define CLKC_ST_LF_LOCK 6

`define CLKC_CPU_DIV_RST 3'h1
`define CLKC_CPU_DIV_MAX 3'h5
`define CLKC_HS_TRIM_RST 6'h00
`define CLKC_PULL_RST 4'h0
`define CLKC_CUR_RST 2'h0
`define CLKC_PU_RST 1'b1

`define CLKC_CLK_HZ 64'd25000000
`define CLKC_HS_SETTLE_US 64'd1000
`define CLKC_LF_SETTLE_MS 64'd1000

`endif

/* File: core/clkc_pkg.sv */
// Types shared by the clock selector modules.
package clkc_pkg;
   typedef enum logic [1:0] {HS_ON_RC, HS_WAIT_XTAL, HS_ON_XTAL} clkc_hs_state_t;
   typedef enum logic [1:0] {LF_INT, LF_XTAL, LF_EXT} clkc_lf_src_t;
   typedef struct packed {
      logic in_pullup;
      logic out_pullup;
      logic in_oe_n;
      logic out_oe_n;
   } clkc_pins_t;
endpackage

/* File: core/clkc_settle.sv */
// Crystal stabilisation counter: done rises once run has held for CYCLES clocks.
module clkc_settle #(
   parameter int CYCLES = 25000,
   parameter int CNT_W = 25
) (
   input wire logic CLK, // system clock
   input wire logic RST, // synchronous reset
   input wire logic start, // restart the count
   input wire logic run, // crystal is powered
   output logic done // crystal judged stable
);
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic next_done;

   always_comb begin
      next_cnt = cnt;
      next_done = done;
      if (start || !run) begin
         next_cnt = '0;
         next_done = 1'b0;
      end else if (!done) begin
         next_cnt = cnt + 1'b1;
         next_done = (cnt == CNT_W'(CYCLES - 1));
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         cnt <= '0;
         done <= 1'b0;
      end else begin
         cnt <= next_cnt;
         done <= next_done;
      end
   end
endmodule

/* File: core/clkc_div.sv */
// CPU and peripheral clock dividers, issued as one-cycle ticks of the system clock.
module clkc_div (
   input wire logic CLK, // system clock
   input wire logic RST, // synchronous reset
   input wire logic [2:0] div_code, // divide by 2**div_code; codes 5 to 7 all divide by 32
   output logic cpu_tick, // one pulse per CPU clock period
   output logic periph_tick // one pulse per two system clocks
);
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic [4:0] mask;
   logic next_cpu;
   logic next_periph;

   always_comb begin
      mask = 5'((6'h01 << div_code) - 6'h01);
      next_cnt = cnt + 5'h01;
      next_cpu = ((cnt & mask) == mask);
      next_periph = cnt[0];
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         cnt <= 5'h00;
         cpu_tick <= 1'b0;
         periph_tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         cpu_tick <= next_cpu;
         periph_tick <= next_periph;
      end
   end
endmodule

/* File: core/clkc_top.sv */
// System and low-frequency clock selection with an APB register file.
`include "clkc_defs.svh"
module clkc_top #(
   parameter int HS_SETTLE_CYCLES =
      int'((`CLKC_HS_SETTLE_US * `CLKC_CLK_HZ + 64'd999999) / 64'd1000000),
   parameter int LF_SETTLE_CYCLES =
      int'((`CLKC_LF_SETTLE_MS * `CLKC_CLK_HZ + 64'd999) / 64'd1000)
) (
   input wire logic CLK, // system clock, 25 MHz
   input wire logic RST, // synchronous reset, active high
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB access phase
   input wire logic PWRITE, // APB write
   input wire logic [11:0] PADDR, // APB byte address
   input wire logic [31:0] PWDATA, // APB write data
   output logic [31:0] PRDATA, // APB read data
   output logic PREADY, // APB ready
   output logic PSLVERR, // APB error on unmapped address
   input wire logic WAKE, // one-cycle pulse on leaving sleep
   output logic SYS_SRC_XTAL, // system clock taken from crystal
   output logic HS_XTAL_EN, // high-speed crystal powered
   output logic CPU_TICK, // CPU clock enable tick
   output logic PERIPH_TICK, // peripheral clock enable tick
   output logic [5:0] HS_RC_TRIM, // RC oscillator trim
   output logic [3:0] XTAL_PULL, // extra crystal load capacitance
   output logic [1:0] LF_EXT_CURRENT, // clock module current setting
   output clkc_pkg::clkc_lf_src_t LF_SRC, // low-frequency clock source
   output logic LF_XTAL_EN, // low-frequency crystal powered
   output clkc_pkg::clkc_pins_t LF_PINS // pull-ups and directions of both pins
);
   import clkc_pkg::*;

   clkc_hs_state_t hs_state;
   clkc_hs_state_t next_hs_state;
   logic manual;
   logic next_manual;
   logic [2:0] div_code;
   logic [2:0] next_div_code;
   logic [5:0] next_hs_trim;
   logic [3:0] next_pull;
   logic [1:0] next_cur;
   clkc_lf_src_t lf_sel;
   clkc_lf_src_t next_lf_sel;
   clkc_lf_src_t next_lf_src;
   logic lf_now;
   logic next_lf_now;
   logic sw_in_pu;
   logic next_sw_in_pu;
   logic sw_out_pu;
   logic next_sw_out_pu;
   clkc_pins_t next_pins;
   logic next_lf_xtal_en;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic hs_start;
   logic lf_start;
   logic hs_ready;
   logic lf_ready;
   logic wr;
   logic rd;
   logic hit;

   // Codes above five would ask for a divisor the hardware lacks; they saturate.
   function automatic logic [2:0] clamp_div(input logic [2:0] code);
      clamp_div = (code > `CLKC_CPU_DIV_MAX) ? `CLKC_CPU_DIV_MAX : code;
   endfunction

   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
      addr_is = (a == ofs);
   endfunction

   clkc_settle #(
      .CYCLES(HS_SETTLE_CYCLES),
      .CNT_W(16)
   ) u_hs_settle (
      .CLK(CLK),
      .RST(RST),
      .start(hs_start),
      .run(HS_XTAL_EN),
      .done(hs_ready)
   );

   clkc_settle #(
      .CYCLES(LF_SETTLE_CYCLES),
      .CNT_W(26)
   ) u_lf_settle (
      .CLK(CLK),
      .RST(RST),
      .start(lf_start),
      .run(LF_XTAL_EN),
      .done(lf_ready)
   );

   clkc_div u_div (
      .CLK(CLK),
      .RST(RST),
      .div_code(div_code),
      .cpu_tick(CPU_TICK),
      .periph_tick(PERIPH_TICK)
   );

   // The write takes effect in the access cycle in which PREADY is already high.
   always_comb begin
      wr = PSEL && PENABLE && PREADY && PWRITE;
      rd = PSEL && !PENABLE;
      hit = addr_is(PADDR, `CLKC_CTRL_OFS) || addr_is(PADDR, `CLKC_LFCTRL_OFS) ||
            addr_is(PADDR, `CLKC_TRIM_OFS) || addr_is(PADDR, `CLKC_STATUS_OFS);
   end

   // APB answer and read mux.
   always_comb begin
      next_pready = PSEL && !PENABLE;
      next_pslverr = PSEL && !PENABLE && !hit;
      next_prdata = PRDATA;
      if (rd) begin
         next_prdata = 32'h00000000;
         if (addr_is(PADDR, `CLKC_CTRL_OFS)) begin
            next_prdata[`CLKC_CTRL_SRC_RC] = (hs_state == HS_ON_RC);
            next_prdata[`CLKC_CTRL_MANUAL] = manual;
            next_prdata[`CLKC_CTRL_DIV_MSB:`CLKC_CTRL_DIV_LSB] = div_code;
         end else if (addr_is(PADDR, `CLKC_LFCTRL_OFS)) begin
            next_prdata[`CLKC_LF_MODE_MSB:`CLKC_LF_MODE_LSB] = lf_sel;
            next_prdata[`CLKC_LF_NOW] = lf_now;
            next_prdata[`CLKC_LF_IN_PU] = sw_in_pu;
            next_prdata[`CLKC_LF_OUT_PU] = sw_out_pu;
         end else if (addr_is(PADDR, `CLKC_TRIM_OFS)) begin
            next_prdata[`CLKC_TRIM_HS_MSB:`CLKC_TRIM_HS_LSB] = HS_RC_TRIM;
            next_prdata[`CLKC_TRIM_PULL_MSB:`CLKC_TRIM_PULL_LSB] = XTAL_PULL;
            next_prdata[`CLKC_TRIM_CUR_MSB:`CLKC_TRIM_CUR_LSB] = LF_EXT_CURRENT;
         end else if (addr_is(PADDR, `CLKC_STATUS_OFS)) begin
            next_prdata[`CLKC_ST_SRC_RC] = !SYS_SRC_XTAL;
            next_prdata[`CLKC_ST_HS_RDY] = hs_ready;
            next_prdata[`CLKC_ST_LF_RDY] = (LF_SRC == LF_EXT) || lf_ready;
            next_prdata[`CLKC_ST_LF_SRC_MSB:`CLKC_ST_LF_SRC_LSB] = LF_SRC;
            next_prdata[`CLKC_ST_LF_LOCK] = (lf_sel != LF_INT);
         end
      end
   end

   // High-speed source control and the settings registers.
   always_comb begin
      next_hs_state = hs_state;
      next_manual = manual;
      next_div_code = div_code;
      next_hs_trim = HS_RC_TRIM;
      next_pull = XTAL_PULL;
      next_cur = LF_EXT_CURRENT;
      hs_start = 1'b0;
      case (hs_state)
         HS_WAIT_XTAL: begin
            if (hs_ready) begin
               next_hs_state = HS_ON_XTAL;
            end
         end
         HS_ON_XTAL: begin
            if (!hs_ready) begin
               next_hs_state = HS_WAIT_XTAL;
            end
         end
         HS_ON_RC: begin
            next_hs_state = HS_ON_RC;
         end
         default: begin
            next_hs_state = HS_ON_RC;
         end
      endcase
      if (wr && addr_is(PADDR, `CLKC_CTRL_OFS)) begin
         next_manual = PWDATA[`CLKC_CTRL_MANUAL];
         next_div_code = clamp_div(PWDATA[`CLKC_CTRL_DIV_MSB:`CLKC_CTRL_DIV_LSB]);
         if (PWDATA[`CLKC_CTRL_SRC_RC]) begin
            next_hs_state = HS_ON_RC;
         end else if (hs_state == HS_ON_RC) begin
            next_hs_state = HS_WAIT_XTAL;
            hs_start = 1'b1;
         end
      end
      if (wr && addr_is(PADDR, `CLKC_TRIM_OFS)) begin
         next_hs_trim = PWDATA[`CLKC_TRIM_HS_MSB:`CLKC_TRIM_HS_LSB];
         next_pull = PWDATA[`CLKC_TRIM_PULL_MSB:`CLKC_TRIM_PULL_LSB];
         next_cur = PWDATA[`CLKC_TRIM_CUR_MSB:`CLKC_TRIM_CUR_LSB];
      end
      // Sleep drops the crystal, so waking always restarts its count from zero.
      if (WAKE) begin
         hs_start = 1'b1;
         next_hs_state = manual ? HS_ON_RC : HS_WAIT_XTAL;
      end
   end

   // Low-frequency source control; the lock means a write of the internal source is ignored.
   always_comb begin
      next_lf_sel = lf_sel;
      next_lf_now = lf_now;
      next_sw_in_pu = sw_in_pu;
      next_sw_out_pu = sw_out_pu;
      lf_start = 1'b0;
      if (wr && addr_is(PADDR, `CLKC_LFCTRL_OFS)) begin
         next_sw_in_pu = PWDATA[`CLKC_LF_IN_PU];
         next_sw_out_pu = PWDATA[`CLKC_LF_OUT_PU];
         next_lf_now = PWDATA[`CLKC_LF_NOW];
         case (PWDATA[`CLKC_LF_MODE_MSB:`CLKC_LF_MODE_LSB])
            2'h1: begin
               next_lf_sel = LF_XTAL;
               lf_start = (lf_sel != LF_XTAL);
            end
            2'h2: begin
               next_lf_sel = LF_EXT;
            end
            default: begin
               next_lf_sel = lf_sel;
            end
         endcase
      end
      next_lf_xtal_en = (next_lf_sel == LF_XTAL);
      next_lf_src = LF_SRC;
      case (next_lf_sel)
         LF_XTAL: begin
            if (next_lf_now || lf_ready) begin
               next_lf_src = LF_XTAL;
            end
         end
         LF_EXT: begin
            next_lf_src = LF_EXT;
         end
         default: begin
            next_lf_src = LF_SRC;
         end
      endcase
      next_pins.in_pullup = next_sw_in_pu && (next_lf_sel != LF_XTAL);
      next_pins.out_pullup = next_sw_out_pu && (next_lf_sel != LF_XTAL);
      next_pins.in_oe_n = 1'b1;
      next_pins.out_oe_n = 1'b1;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         hs_state <= HS_WAIT_XTAL;
         manual <= 1'b0;
         div_code <= `CLKC_CPU_DIV_RST;
         HS_RC_TRIM <= `CLKC_HS_TRIM_RST;
         XTAL_PULL <= `CLKC_PULL_RST;
         LF_EXT_CURRENT <= `CLKC_CUR_RST;
         SYS_SRC_XTAL <= 1'b0;
         HS_XTAL_EN <= 1'b0;
         lf_sel <= LF_INT;
         LF_SRC <= LF_INT;
         lf_now <= 1'b0;
         sw_in_pu <= `CLKC_PU_RST;
         sw_out_pu <= `CLKC_PU_RST;
         LF_XTAL_EN <= 1'b0;
         LF_PINS <= '{in_pullup: 1'b1, out_pullup: 1'b1, in_oe_n: 1'b1, out_oe_n: 1'b1};
         PRDATA <= 32'h00000000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         hs_state <= next_hs_state;
         manual <= next_manual;
         div_code <= next_div_code;
         HS_RC_TRIM <= next_hs_trim;
         XTAL_PULL <= next_pull;
         LF_EXT_CURRENT <= next_cur;
         SYS_SRC_XTAL <= (next_hs_state == HS_ON_XTAL);
         HS_XTAL_EN <= (next_hs_state != HS_ON_RC) && !hs_start;
         lf_sel <= next_lf_sel;
         LF_SRC <= next_lf_src;
         lf_now <= next_lf_now;
         sw_in_pu <= next_sw_in_pu;
         sw_out_pu <= next_sw_out_pu;
         LF_XTAL_EN <= next_lf_xtal_en && !lf_start;
         LF_PINS <= next_pins;
         PRDATA <= next_prdata;
         PREADY <= next_pready;
         PSLVERR <= next_pslverr;
      end
   end
endmodule

/* File: bench/clkc_chk.sv */
// Port-level assertions for the clock selector.
`include "clkc_defs.svh"
module clkc_chk
   import clkc_pkg::*;
(
   input wire logic CLK, // system clock
   input wire logic RST, // synchronous reset
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB access phase
   input wire logic [11:0] PADDR, // APB address
   input wire logic PREADY, // APB ready
   input wire logic PSLVERR, // APB error
   input wire logic WAKE, // sleep exit pulse
   input wire logic SYS_SRC_XTAL, // crystal is source
   input wire logic HS_XTAL_EN, // crystal powered
   input wire logic PERIPH_TICK, // peripheral tick
   input wire clkc_lf_src_t LF_SRC, // low-frequency source
   input wire clkc_pins_t LF_PINS // pin controls
);
   timeunit 1ns;
   timeprecision 1ps;
   logic unmapped;
   assign unmapped = !(PADDR inside {`CLKC_CTRL_OFS, `CLKC_LFCTRL_OFS, `CLKC_TRIM_OFS,
      `CLKC_STATUS_OFS});
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   property p_rst_rc; $fell(RST) |-> !SYS_SRC_XTAL; endproperty
   a_rst_rc: assert property (p_rst_rc) else $error("crystal in use right after reset");
   property p_hs_start; $fell(RST) |=> HS_XTAL_EN; endproperty
   a_hs_start: assert property (p_hs_start) else $error("crystal not started");
   property p_wake_rc; WAKE |=> !SYS_SRC_XTAL; endproperty
   a_wake_rc: assert property (p_wake_rc) else $error("wake did not restart on RC");
   property p_xtal_first; !HS_XTAL_EN |=> !SYS_SRC_XTAL; endproperty
   a_xtal_first: assert property (p_xtal_first) else $error("switch to unpowered crystal");
   property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
   a_ready: assert property (p_ready) else $error("access phase not answered at once");
   property p_slverr; PSEL && PENABLE && PREADY |-> PSLVERR == unmapped; endproperty
   a_slverr: assert property (p_slverr) else $error("error response wrong for address");
   property p_periph; PERIPH_TICK |=> !PERIPH_TICK ##1 PERIPH_TICK; endproperty
   a_periph: assert property (p_periph) else $error("peripheral tick not every second");
   property p_pins_in; LF_PINS.in_oe_n && LF_PINS.out_oe_n; endproperty
   a_pins_in: assert property (p_pins_in) else $error("oscillator pin driven");
   property p_xtal_pu; LF_SRC == LF_XTAL |-> !LF_PINS.in_pullup && !LF_PINS.out_pullup; endproperty
   a_xtal_pu: assert property (p_xtal_pu) else $error("pull-up left on with crystal");
   property p_lock; LF_SRC != LF_INT |=> LF_SRC != LF_INT; endproperty
   a_lock: assert property (p_lock) else $error("low-frequency source went back");
   c_wake: cover property (WAKE);
   c_switch: cover property ($rose(SYS_SRC_XTAL));
   c_ext: cover property (LF_SRC == LF_EXT);
endmodule

/* File: bench/clkc_tb_top.sv */
// Self-checking bench for the clock selector.
`include "clkc_defs.svh"
module clkc_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import clkc_pkg::*;
   localparam int HS = 20;
   localparam int LF = 40;
   localparam logic [11:0] a_ct = `CLKC_CTRL_OFS;
   localparam logic [11:0] a_lf = `CLKC_LFCTRL_OFS;
   localparam logic [11:0] a_tr = `CLKC_TRIM_OFS;
   localparam logic [11:0] a_st = `CLKC_STATUS_OFS;
   typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;
      logic er;} clkc_row_t;
   clkc_row_t rows [12];
   logic clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wake = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, sys, hs_en, cpu_tick, per_tick, lf_en, er;
   logic [5:0] trim;
   logic [3:0] pull;
   logic [1:0] cur;
   clkc_lf_src_t lf_src;
   clkc_pins_t pins;
   int n_errors = 0, checks = 0, cyc = 0, t0, n;
   clkc_top #(.HS_SETTLE_CYCLES(HS), .LF_SETTLE_CYCLES(LF)) u_dut (.CLK(clk), .RST(rst),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .WAKE(wake), .SYS_SRC_XTAL(sys),
      .HS_XTAL_EN(hs_en), .CPU_TICK(cpu_tick), .PERIPH_TICK(per_tick), .HS_RC_TRIM(trim),
      .XTAL_PULL(pull), .LF_EXT_CURRENT(cur), .LF_SRC(lf_src), .LF_XTAL_EN(lf_en), .LF_PINS(pins));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task close_out;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // The request is held until pready is seen; a gap cycle keeps drivers single per step.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task rst_run;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t0 = cyc;
   endtask
   task wsys;
      for (n = 0; n < 200 && sys !== 1'b1; n++) @(posedge clk);
   endtask
   task wk;
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      @(posedge clk);
   endtask
   // The tick visible on entry was still made with the old divisor, so wait one edge before looking.
   task gap;
      @(posedge clk);
      for (n = 0; n < 80 && cpu_tick !== 1'b1; n++) @(posedge clk);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (cpu_tick !== 1'b1 && n < 80);
   endtask
   initial begin
      #(40 * 6000);
      n_errors++;
      close_out;
   end
   initial begin
      rows = '{'{0, a_ct, 0, 32'h04, 0}, '{1, a_ct, 32'h00, 0, 0}, '{0, a_ct, 0, 32'h00, 0},
         '{1, a_ct, 32'h0c, 0, 0}, '{0, a_ct, 0, 32'h0c, 0}, '{1, a_ct, 32'h14, 0, 0},
         '{0, a_ct, 0, 32'h14, 0}, '{1, a_ct, 32'h1c, 0, 0}, '{0, a_ct, 0, 32'h14, 0},
         '{1, a_tr, 32'h0003_0a2b, 0, 0}, '{0, a_tr, 0, 32'h0003_0a2b, 0},
         '{0, 12'h010, 0, 32'h0, 1}};
      rst_run;
      chk("sys after reset", sys, 1'b0);
      chk("lf after reset", lf_src, LF_INT);
      chk("pins after reset", pins, 4'hf);
      apb(0, a_tr, 32'h0);
      chk("trim at start", rd, 32'h0);
      wsys;
      chk("switch delay", (cyc - t0) >= HS && (cyc - t0) <= HS + 4, 1'b1);
      gap;
      chk("default gap", n, 2);
      t0 = per_tick;
      @(posedge clk);
      chk("periph halves", per_tick, !t0[0]);
      $display("reset test done");
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk("slverr", er, rows[i].er);
         if (!rows[i].w) chk("rdata", rd, rows[i].e);
         if (rows[i].w && rows[i].a == a_ct) begin
            gap;
            chk("cpu gap", n, 32'h1 << (rows[i].d[4:2] > 5 ? 5 : rows[i].d[4:2]));
         end
      end
      chk("rc trim", trim, 6'h2b);
      chk("xtal pull", pull, 4'ha);
      chk("module current", cur, 2'h3);
      $display("table test done");
      apb(1, a_ct, 32'h05);
      chk("sys forced rc", sys, 1'b0);
      chk("crystal off on rc", hs_en, 1'b0);
      apb(0, a_st, 0);
      chk("status rc", rd[0], 1'b1);
      apb(1, a_ct, 32'h04);
      wsys;
      chk("sys back on xtal", sys, 1'b1);
      apb(0, a_st, 0);
      chk("status xtal", rd[1:0], 2'b10);
      $display("source test done");
      wk;
      chk("wake rc", sys, 1'b0);
      wsys;
      chk("wake auto switch", n <= HS + 4, 1'b1);
      apb(1, a_ct, 32'h06);
      wk;
      repeat (HS + 10) @(posedge clk);
      chk("manual stays rc", sys, 1'b0);
      apb(1, a_ct, 32'h04);
      $display("wake test done");
      apb(1, a_lf, 32'h19);
      chk("xtal pins", pins, 4'b0011);
      for (n = 0; n < LF + 10 && lf_src !== LF_XTAL; n++) @(posedge clk);
      chk("lf xtal ready time", n >= LF - 4 && n <= LF + 6, 1'b1);
      chk("lf xtal powered", lf_en, 1'b1);
      apb(0, a_st, 0);
      chk("lf ready and lock", {rd[6], rd[2]}, 2'b11);
      apb(1, a_lf, 32'h00);
      chk("lf locked", lf_src, LF_XTAL);
      apb(1, a_lf, 32'h12);
      chk("lf module", lf_src, LF_EXT);
      chk("lf xtal off", lf_en, 1'b0);
      chk("module pins", pins, 4'b0111);
      $display("slow clock test done");
      rst_run;
      chk("lf reset again", lf_src, LF_INT);
      apb(1, a_lf, 32'h05);
      chk("lf switch now", lf_src, LF_XTAL);
      $display("switch now test done");
      close_out;
   end
endmodule
bind clkc_top clkc_chk u_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .WAKE(WAKE), .SYS_SRC_XTAL(SYS_SRC_XTAL),
   .HS_XTAL_EN(HS_XTAL_EN), .PERIPH_TICK(PERIPH_TICK), .LF_SRC(LF_SRC), .LF_PINS(LF_PINS));
